// ===== verilog/mrxfe_cfg.svh
// constants of the mii/smii receive front end
`ifndef MRXFE_CFG_SVH
`define MRXFE_CFG_SVH
// ----------------------------------------------------------------
// pin modes
// ----------------------------------------------------------------
`define MRXFE_MODE_MII      2'h0
`define MRXFE_MODE_SMII_REF 2'h1
`define MRXFE_MODE_SMII_SS  2'h2
// ----------------------------------------------------------------
// geometry, reset values and timing
// ----------------------------------------------------------------
`define MRXFE_PORTS         4
`define MRXFE_SEG_BITS      10
`define MRXFE_SEG_LAST      4'h9
`define MRXFE_CNT_RST       4'h0
`define MRXFE_FIFO_DEPTH    4
`define MRXFE_FIFO_AW       2
`define MRXFE_SYS_CLK_KHZ   100000
`define MRXFE_REF_CLK_KHZ   125000
`endif

// ===== verilog/mrxfe_pkg.sv
// types shared by the receive front end modules
`include "mrxfe_cfg.svh"
package mrxfe_pkg;
  typedef enum logic [1:0] {
    MRXFE_MII      = `MRXFE_MODE_MII,
    MRXFE_SMII_REF = `MRXFE_MODE_SMII_REF,
    MRXFE_SMII_SS  = `MRXFE_MODE_SMII_SS
  } mrxfe_mode_t;
  typedef enum logic [1:0] {
    SEG_IDLE = 2'b00,
    SEG_HUNT = 2'b01,
    SEG_RUN  = 2'b10
  } mrxfe_seg_state_t;
  typedef struct packed {
    logic        is_mii;
    logic [39:0] payload;
  } mrxfe_word_t;
endpackage : mrxfe_pkg

// ===== verilog/mrxfe_stream_if.sv
// valid/ready stream carrier between the front end modules
`timescale 1ns/10ps
`default_nettype none
interface mrxfe_stream_if #(parameter int W = 41);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mrxfe_stream_if
`default_nettype wire

// ===== verilog/mrxfe_sync.sv
// two-flop level synchroniser, one stage pair per bit
`timescale 1ns/10ps
`default_nettype none
module mrxfe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : mrxfe_sync
`default_nettype wire

// ===== verilog/mrxfe_fifo.sv
// dual-clock fifo with gray-coded pointers
`timescale 1ns/10ps
`default_nettype none
module mrxfe_fifo #(
  parameter int W     = 41,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  input  wire logic     wclk_in,
  input  wire logic     wrstn_in,
  input  wire logic     rclk_in,
  input  wire logic     rrstn_in,
  mrxfe_stream_if.snk   wr_s,
  mrxfe_stream_if.src   rd_s
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin, wgray, rbin, rgray, rgray_w, wgray_r;
  wire  [AW:0]  next_wbin = wbin + {{AW{1'b0}}, 1'b1};
  wire  [AW:0]  next_rbin = rbin + {{AW{1'b0}}, 1'b1};
  wire          full  = (wgray == {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
  wire          empty = (rgray == wgray_r);
  wire          do_wr = wr_s.valid & ~full;
  wire          do_rd = rd_s.ready & ~empty;

  assign wr_s.ready = ~full;
  assign rd_s.valid = ~empty;
  assign rd_s.data  = mem[rbin[AW-1:0]];

  // write side: storage and pointer on the link clock
  always_ff @(posedge wclk_in) begin
    if (do_wr) mem[wbin[AW-1:0]] <= wr_s.data;
  end
  always_ff @(posedge wclk_in) begin
    if (!wrstn_in) begin
      wbin  <= '0;
      wgray <= '0;
    end else if (do_wr) begin
      wbin  <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
    end
  end
  // read side pointer on the system clock
  always_ff @(posedge rclk_in) begin
    if (!rrstn_in) begin
      rbin  <= '0;
      rgray <= '0;
    end else if (do_rd) begin
      rbin  <= next_rbin;
      rgray <= next_rbin ^ (next_rbin >> 1);
    end
  end
  // only gray codes cross, so one bit changes at a time
  mrxfe_sync #(.W(AW + 1)) u_r2w (
    .clk_in  (wclk_in),
    .rstn_in (wrstn_in),
    .d_in    (rgray),
    .q_out   (rgray_w)
  );
  mrxfe_sync #(.W(AW + 1)) u_w2r (
    .clk_in  (rclk_in),
    .rstn_in (rrstn_in),
    .d_in    (wgray),
    .q_out   (wgray_r)
  );
endmodule : mrxfe_fifo
`default_nettype wire

// ===== verilog/mrxfe_top.sv
// mii/smii receive pin front end with link-clock capture and fifo
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1: each of the four receive pins is one bit of the mii nibble or one serial smii port line, chosen by mode.
// R2: in plain smii mode each serial line is captured on the rising edge of the shared reference clock.
// R3: in source-synchronous smii mode each line is captured on the rising edge of the phy receive clock.
// R4: in mii mode the phy raises receive-valid during frame data and only those nibbles are taken as data.
// R5: in source-synchronous mode the phy pulses sync every ten clocks and that pulse marks bit zero of a segment.
// R6: the source-synchronous receive logic runs from a receive clock of nominally 125 MHz.
// R7: the port holds no address hashing filter; any filtering is done beyond this logic.
// R8: in smii mode each of the four serial lines is its own port with its own receive stream.
// R9: in mii mode the nibble is sampled synchronously to the phy mii receive clock.
// R10: in smii mode the ten bits after each segment start are shifted per port and handed on as one unit.
module mrxfe_top
  import mrxfe_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        link_clk_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic [3:0]  mii_rx_nibble_in,
  input  wire logic        rx_valid_in,
  input  wire logic        seg_ready_in,
  input  wire logic        err_clr_in,
  output logic             seg_valid_out,
  output logic             seg_is_mii_out,
  output logic [39:0]      seg_data_out,
  output logic             ref_sync_out,
  output logic             overflow_out,
  output logic             sync_err_out
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int PORTS    = `MRXFE_PORTS;
  localparam int SEG_BITS = `MRXFE_SEG_BITS;
  localparam int WORD_W   = $bits(mrxfe_word_t);

  logic                link_rstn;
  logic                link_rst_meta;
  logic [1:0]          link_mode_raw;
  mrxfe_mode_t         link_mode;
  logic [3:0]          pin_data;
  logic                pin_ctl;
  logic [SEG_BITS-1:0] seg_sr [PORTS];
  logic [39:0]         seg_flat;
  logic [3:0]          bit_cnt;
  logic [3:0]          next_bit_cnt;
  mrxfe_seg_state_t    seg_state;
  mrxfe_seg_state_t    next_seg_state;
  logic                ovf_tgl;
  logic                serr_tgl;
  logic [1:0]          evt_sync;
  logic [1:0]          evt_prev;
  logic [1:0]          live_sr;

  mrxfe_stream_if #(.W(WORD_W)) wr_s ();
  mrxfe_stream_if #(.W(WORD_W)) rd_s ();

  // ----------------------------------------------------------------
  // link-domain reset and mode
  // ----------------------------------------------------------------
  // reset release is carried over by two flops; the link clock may be
  // stopped, so the link side stays in reset until it sees edges
  always_ff @(posedge link_clk_in) begin
    link_rst_meta <= rstn_in;
    link_rstn     <= link_rst_meta;
  end

  // mode is a static strap level, resynchronised for the link side
  mrxfe_sync #(.W(2)) u_mode_sync (
    .clk_in  (link_clk_in),
    .rstn_in (link_rstn),
    .d_in    (mode_in),
    .q_out   (link_mode_raw)
  );
  assign link_mode = mrxfe_mode_t'(link_mode_raw);

  // ----------------------------------------------------------------
  // strap settle
  // ----------------------------------------------------------------
  // the strap copy reads as the mii code for two link edges after
  // reset; a matching chain of ones keeps every decode off until the
  // real code is through, so a sync pulse is never taken as a nibble
  wire mode_live = live_sr[1];

  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) live_sr <= 2'h0;
    else live_sr <= {live_sr[0], 1'b1};
  end

  // ----------------------------------------------------------------
  // pin capture
  // ----------------------------------------------------------------
  // the link clock is the mii receive clock, the shared reference
  // clock or the phy receive clock (125 MHz), per the strapped mode;
  // pins are sampled once on its rising edge [R2] [R3] [R6] [R9]
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      pin_data <= 4'h0;
      pin_ctl  <= 1'b0;
    end else begin
      pin_data <= mii_rx_nibble_in;
      pin_ctl  <= rx_valid_in;
    end
  end

  // the same pins carry two functions; the decodes below pick one
  wire [3:0] serial_rx_port_line = pin_data;        // [R1]
  wire [3:0] mii_rx_nibble       = pin_data;        // [R1]
  wire       rx_segment_sync     = pin_ctl;
  wire       rx_valid            = pin_ctl;
  wire       is_mii  = mode_live & (link_mode == MRXFE_MII);
  wire       is_ref  = mode_live & (link_mode == MRXFE_SMII_REF);
  wire       is_ss   = mode_live & (link_mode == MRXFE_SMII_SS);
  wire       is_smii = is_ref | is_ss;

  // ----------------------------------------------------------------
  // smii segment tracking
  // ----------------------------------------------------------------
  // bit_cnt holds the index of the bit most recently shifted in
  wire seg_last = (bit_cnt == `MRXFE_SEG_LAST);
  wire in_run   = (seg_state == SEG_RUN);
  wire sync_hit = is_ss & rx_segment_sync;          // [R5]
  // plain smii frames itself from a free-running ten-bit count
  wire ref_start = is_ref & (~in_run | seg_last);
  wire seg_start = is_ss ? sync_hit : ref_start;
  // a full segment is complete once bit nine sits in the shifters
  wire seg_push  = is_smii & in_run & seg_last;     // [R10]
  // sync too early or missing at a boundary breaks the framing
  wire sync_early = is_ss & in_run & sync_hit & ~seg_last;
  wire sync_miss  = is_ss & in_run & ~sync_hit & seg_last;

  // next bit count: restart on a segment start, else count to nine
  always_comb begin
    next_bit_cnt = bit_cnt;
    if (!is_smii) begin
      next_bit_cnt = `MRXFE_CNT_RST;
    end else if (seg_start) begin
      next_bit_cnt = `MRXFE_CNT_RST;                  // [R5]
    end else if (!seg_last) begin
      next_bit_cnt = bit_cnt + 4'h1;
    end
  end

  // framing state: idle outside smii, hunt for sync in source-sync mode (plain smii goes straight to run), then run
  always_comb begin
    next_seg_state = seg_state;
    case (seg_state)
      SEG_IDLE: begin
        if (is_ref) next_seg_state = SEG_RUN;
        else if (sync_hit) next_seg_state = SEG_RUN;
        else if (is_ss) next_seg_state = SEG_HUNT;
      end
      SEG_HUNT: begin
        if (sync_hit) next_seg_state = SEG_RUN;     // [R5]
      end
      SEG_RUN: begin
        if (sync_miss) next_seg_state = SEG_HUNT;
      end
      default: next_seg_state = SEG_IDLE;
    endcase
    if (!is_smii) next_seg_state = SEG_IDLE;
  end

  // state and counter registers
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      seg_state <= SEG_IDLE;
      bit_cnt   <= `MRXFE_CNT_RST;
    end else begin
      seg_state <= next_seg_state;
      bit_cnt   <= next_bit_cnt;
    end
  end

  // ----------------------------------------------------------------
  // per-port shift registers
  // ----------------------------------------------------------------
  // every line has its own shifter, so the four streams never mix;
  // the first bit of a segment ends up in bit zero [R8] [R10]
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    always_ff @(posedge link_clk_in) begin
      if (!link_rstn) begin
        seg_sr[p] <= '0;
      end else if (is_smii) begin
        seg_sr[p] <= {serial_rx_port_line[p], seg_sr[p][SEG_BITS-1:1]};
      end
    end
    assign seg_flat[p*SEG_BITS +: SEG_BITS] = seg_sr[p];
  end

  // ----------------------------------------------------------------
  // mii nibble qualification
  // ----------------------------------------------------------------
  // nibbles outside receive-valid are idle or noise and are dropped
  wire mii_push = is_mii & rx_valid;                // [R4]

  // no address or hash match exists here: every qualified word goes
  // to the mac, which filters frames itself [R7]
  wire         any_push  = mii_push | seg_push;
  mrxfe_word_t push_word;
  assign push_word.is_mii  = mii_push;
  assign push_word.payload = mii_push ? {36'h0, mii_rx_nibble} : seg_flat;

  // ----------------------------------------------------------------
  // fifo write and link-side error events
  // ----------------------------------------------------------------
  // the phy cannot be held off; a word offered while the fifo is full
  // is lost and flagged rather than stalling the pins
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      wr_s.valid <= 1'b0;
      wr_s.data  <= '0;
    end else begin
      wr_s.valid <= any_push;
      wr_s.data  <= push_word;
    end
  end

  // events cross as toggles so no pulse is lost to the slower side
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) begin
      ovf_tgl  <= 1'b0;
      serr_tgl <= 1'b0;
    end else begin
      ovf_tgl  <= ovf_tgl ^ (wr_s.valid & ~wr_s.ready);
      serr_tgl <= serr_tgl ^ (sync_early | sync_miss);
    end
  end

  // plain smii: the device marks each segment start for the phy
  always_ff @(posedge link_clk_in) begin
    if (!link_rstn) ref_sync_out <= 1'b0;
    else ref_sync_out <= ref_start;                 // [R2]
  end

  // ----------------------------------------------------------------
  // clock-domain fifo
  // ----------------------------------------------------------------
  mrxfe_fifo #(
    .W     (WORD_W),
    .DEPTH (`MRXFE_FIFO_DEPTH),
    .AW    (`MRXFE_FIFO_AW)
  ) u_fifo (
    .wclk_in  (link_clk_in),
    .wrstn_in (link_rstn),
    .rclk_in  (clk_in),
    .rrstn_in (rstn_in),
    .wr_s     (wr_s),
    .rd_s     (rd_s)
  );

  // ----------------------------------------------------------------
  // system-side output stage
  // ----------------------------------------------------------------
  // the output register refills only when empty or being taken, so a
  // stalled consumer backs the fifo up to the link side
  wire         out_free = ~seg_valid_out | seg_ready_in;
  mrxfe_word_t rd_word;
  assign rd_word    = mrxfe_word_t'(rd_s.data);
  assign rd_s.ready = out_free;
  wire   take       = rd_s.valid & out_free;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      seg_valid_out  <= 1'b0;
      seg_is_mii_out <= 1'b0;
      seg_data_out   <= 40'h0;
    end else if (take) begin
      seg_valid_out  <= 1'b1;
      seg_is_mii_out <= rd_word.is_mii;
      seg_data_out   <= rd_word.payload;
    end else if (seg_ready_in) begin
      seg_valid_out  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sticky error flags
  // ----------------------------------------------------------------
  mrxfe_sync #(.W(2)) u_evt_sync (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .d_in    ({serr_tgl, ovf_tgl}),
    .q_out   (evt_sync)
  );

  // edge detect looks at the synchronised copy only
  always_ff @(posedge clk_in) begin
    if (!rstn_in) evt_prev <= 2'h0;
    else evt_prev <= evt_sync;
  end
  wire [1:0] evt_hit = evt_sync ^ evt_prev;

  // a new event in the clearing cycle keeps its flag set
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      overflow_out <= 1'b0;
      sync_err_out <= 1'b0;
    end else begin
      overflow_out <= evt_hit[0] | (overflow_out & ~err_clr_in);
      sync_err_out <= evt_hit[1] | (sync_err_out & ~err_clr_in);
    end
  end
endmodule : mrxfe_top
`default_nettype wire

// ===== verification/mrxfe_checker.sv
// port-level assertions for the receive front end
`timescale 1ns/10ps
`default_nettype none
module mrxfe_checker
  import mrxfe_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        link_clk_in,
  input wire logic [1:0]  mode_in,
  input wire logic [3:0]  mii_rx_nibble_in,
  input wire logic        rx_valid_in,
  input wire logic        seg_ready_in,
  input wire logic        err_clr_in,
  input wire logic        seg_valid_out,
  input wire logic        seg_is_mii_out,
  input wire logic [39:0] seg_data_out,
  input wire logic        ref_sync_out,
  input wire logic        overflow_out,
  input wire logic        sync_err_out
);
  // ----------------------------------------------------------------
  // output stream, system clock side
  // ----------------------------------------------------------------
  valid_hold_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) seg_valid_out && !seg_ready_in |=> seg_valid_out)
    else $error("word withdrawn before taken");
  data_hold_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in)
    seg_valid_out && !seg_ready_in |=> $stable(seg_data_out))
    else $error("word changed before taken");
  mii_word_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) seg_valid_out && seg_is_mii_out
    |-> seg_data_out[39:4] == 36'h0 && mode_in == MRXFE_MII)
    else $error("bad nibble word");
  smii_word_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) seg_valid_out && !seg_is_mii_out
    |-> mode_in inside {MRXFE_SMII_REF, MRXFE_SMII_SS})
    else $error("segment word outside serial mode");
  // synchronous reset clears the outputs on the next edge
  reset_quiet_a: assert property (@(posedge clk_in) !rstn_in
    |=> !seg_valid_out && !overflow_out && !sync_err_out)
    else $error("outputs not cleared by reset");
  ovf_sticky_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) overflow_out && !err_clr_in |=> overflow_out)
    else $error("overflow flag lost");
  serr_sticky_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) sync_err_out && !err_clr_in |=> sync_err_out)
    else $error("sync error flag lost");
  serr_mode_a: assert property (@(posedge clk_in)
    disable iff (!rstn_in) $rose(sync_err_out) |-> mode_in == MRXFE_SMII_SS)
    else $error("sync error outside source-sync mode");
  // ----------------------------------------------------------------
  // segment marker, link clock side
  // ----------------------------------------------------------------
  sync_pulse_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) ref_sync_out |=> !ref_sync_out)
    else $error("segment marker longer than one cycle");
  sync_mode_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) ref_sync_out |-> mode_in == MRXFE_SMII_REF)
    else $error("segment marker outside plain mode");
  sync_period_a: assert property (@(posedge link_clk_in)
    disable iff (!rstn_in) ref_sync_out |-> ##10 ref_sync_out)
    else $error("segment marker not every ten cycles");
endmodule : mrxfe_checker
bind mrxfe_top mrxfe_checker i_chk (.clk_in, .rstn_in, .link_clk_in,
  .mode_in, .mii_rx_nibble_in, .rx_valid_in, .seg_ready_in, .err_clr_in,
  .seg_valid_out, .seg_is_mii_out, .seg_data_out, .ref_sync_out,
  .overflow_out, .sync_err_out);
`default_nettype wire

// ===== verification/mrxfe_phy_model.sv
// phy model: mii nibbles or four serial lines, driven after link edges
`timescale 1ns/10ps
`default_nettype none
module mrxfe_phy_model (
  input  wire logic       link_clk_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       ref_sync_in,
  output logic      [3:0] nib_out,
  output logic            valid_out
);
  logic [4:0]  mq[$];
  logic [39:0] sq[$];
  logic [39:0] cur;
  logic        early;
  int          cnt;
  initial begin
    nib_out = 4'hf;
    valid_out = 1'b0;
    cur = '1;
    early = 1'b0;
    cnt = 0;
  end
  // ----------------------------------------------------------------
  // pin driver; idle serial lines sit high as with a pull-up
  // ----------------------------------------------------------------
  always @(posedge link_clk_in) begin
    #1;
    if (mode_in == 2'h0) begin
      // valid only with queued frame data, idle data keeps toggling
      if (mq.size() > 0) {valid_out, nib_out} = mq.pop_front();
      else {valid_out, nib_out} = {1'b0, ~nib_out};
    end else begin
      cnt = (cnt >= 9) ? 0 : cnt + 1;
      // bit zero enters the device's shifter on the edge whose marker is seen
      // here, two edges after it was driven, so the marker lands on bit two
      if (mode_in == 2'h1 && ref_sync_in) cnt = 2;
      // a commanded early sync restarts the segment count
      if (early && cnt == 4) begin
        cnt = 0;
        early = 1'b0;
      end
      if (cnt == 0) cur = (sq.size() > 0) ? sq.pop_front() : '1;
      valid_out = (mode_in == 2'h2) && (cnt == 0);
      for (int p = 0; p < 4; p++) nib_out[p] = cur[p*10+cnt];
    end
  end
endmodule : mrxfe_phy_model
`default_nettype wire

// ===== verification/mrxfe_top_bench.sv
// self-checking bench for the receive front end
`timescale 1ns/10ps
`default_nettype none
module mrxfe_top_bench;
  import mrxfe_pkg::*;
  logic        clk_in, rstn_in, link_clk_in, seg_ready_in, err_clr_in;
  logic        hold, rx_valid, seg_valid_out, seg_is_mii_out;
  logic        ref_sync_out, overflow_out, sync_err_out;
  logic [1:0]  mode_in;
  logic [3:0]  nib;
  logic [39:0] seg_data_out;
  logic [40:0] expq[$];
  int          errors, check_count;
  mrxfe_top i_dut (.clk_in, .rstn_in, .link_clk_in, .mode_in,
    .mii_rx_nibble_in(nib), .rx_valid_in(rx_valid), .seg_ready_in,
    .err_clr_in, .seg_valid_out, .seg_is_mii_out, .seg_data_out,
    .ref_sync_out, .overflow_out, .sync_err_out);
  mrxfe_phy_model i_phy (.link_clk_in, .mode_in, .ref_sync_in(ref_sync_out),
    .nib_out(nib), .valid_out(rx_valid));
  // ----------------------------------------------------------------
  // clocks, consumer and monitor
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // link clock free-running, phase unrelated to the system clock
  initial begin
    link_clk_in = 1'b0;
    #3.7;
    forever #32 link_clk_in = ~link_clk_in;
  end
  always @(negedge clk_in) seg_ready_in <= !hold && ($urandom % 4 != 0);
  // idle segments carry no frame data, so they are skipped
  always @(posedge clk_in) begin
    if (rstn_in === 1'b1 && seg_valid_out === 1'b1 && seg_ready_in === 1'b1
        && {seg_is_mii_out, seg_data_out} !== {1'b0, 40'hff_ffff_ffff})
      check_word(expq.size() > 0 ? expq.pop_front() : 41'h0,
                 {seg_is_mii_out, seg_data_out});
  end
  task automatic check_word(input logic [40:0] e, input logic [40:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED seg word expected %h seen %h", e, g);
    end
  endtask : check_word
  task automatic check_flag(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : check_flag
  // reset long enough for the link side; mode is strapped meanwhile
  task automatic do_reset(input logic [1:0] m);
    rstn_in = 1'b0;
    mode_in = m;
    repeat (30) @(negedge clk_in);
    check_flag("reset valid", 1'b0, seg_valid_out);
    rstn_in = 1'b1;
    repeat (80) @(negedge clk_in);
  endtask : do_reset
  task automatic drain();
    int n;
    n = 0;
    while (expq.size() > 0 && n < 4000) begin
      @(negedge clk_in);
      n++;
    end
    check_flag("drained", 1'b1, expq.size() == 0);
  endtask : drain
  task automatic pulse_clear();
    err_clr_in = 1'b1;
    @(negedge clk_in);
    err_clr_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask : pulse_clear
  task automatic finish_test();
    if (errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    #400000;
    errors++;
    finish_test();
  end
  initial begin
    logic [39:0] s;
    logic [3:0]  n;
    logic        v;
    errors = 0;
    check_count = 0;
    hold = 1'b0;
    err_clr_in = 1'b0;
    void'($urandom(17634));
    // nibbles with random gaps where receive-valid is low
    do_reset(2'h0);
    for (int i = 0; i < 24; i++) begin
      v = ($urandom % 3) != 0;
      n = 4'($urandom);
      i_phy.mq.push_back({v, n});
      if (v) expq.push_back({1'b1, 36'h0, n});
    end
    drain();
    // plain then source-sync serial segments, four ports each
    for (int m = 1; m < 3; m++) begin
      do_reset(2'(m));
      for (int i = 0; i < 6; i++) begin
        s = 40'({$urandom, $urandom});
        s[0] = 1'b0;
        i_phy.sq.push_back(s);
        expq.push_back({1'b0, s});
      end
      drain();
    end
    // consumer stalls until the fifo refuses words
    hold = 1'b1;
    repeat (900) @(negedge clk_in);
    check_flag("overflow", 1'b1, overflow_out);
    hold = 1'b0;
    repeat (100) @(negedge clk_in);
    pulse_clear();
    check_flag("overflow clear", 1'b0, overflow_out);
    // far side sends its sync early once
    i_phy.early = 1'b1;
    repeat (300) @(negedge clk_in);
    check_flag("sync error", 1'b1, sync_err_out);
    pulse_clear();
    check_flag("sync clear", 1'b0, sync_err_out);
    // unused mode captures nothing
    do_reset(2'h3);
    repeat (200) @(negedge clk_in);
    check_flag("idle mode valid", 1'b0, seg_valid_out);
    finish_test();
  end
endmodule : mrxfe_top_bench
`default_nettype wire
